// ### src/usil_pkg.sv
package usil_pkg;
  localparam int FIELD_W = 16;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_INDEX = 8'h00;
  localparam logic [7:0] OFF_LENGTH = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam int CTRL_HOST_BIT = 0;
  localparam int CTRL_REQ_BIT = 1;
  localparam logic [15:0] FIELD_RST = 16'h0000;
  localparam logic HOST_MODE_RST = 1'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum {USIL_REG_INDEX, USIL_REG_LENGTH, USIL_REG_CTRL, USIL_REG_NONE} usil_reg_t;
endpackage

// ### src/usil_field.sv
`timescale 1ns/10ps
module usil_field #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic host_mode_in,
  input wire logic sw_we_in,
  input wire logic [1:0] sw_strb_in,
  input wire logic [WIDTH-1:0] sw_data_in,
  input wire logic cap_in,
  input wire logic [WIDTH-1:0] cap_data_in,
  output logic [WIDTH-1:0] value_out
);
  logic [WIDTH-1:0] next_value;

  generate
    if (WIDTH != 16) begin : g_bad_width
      $error("usil_field: WIDTH must be 16");
    end
  endgenerate

  always_comb begin
    next_value = value_out;
    if (host_mode_in) begin
      // Byte lanes: low byte in bits 7-0, high byte in bits 15-8
      if (sw_we_in && sw_strb_in[0]) begin
        next_value[7:0] = sw_data_in[7:0];
      end
      if (sw_we_in && sw_strb_in[1]) begin
        next_value[15:8] = sw_data_in[15:8];
      end
    end else if (cap_in) begin
      // Software writes are dropped here; only a received setup changes the value
      next_value = cap_data_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      value_out <= usil_pkg::FIELD_RST;
    end else begin
      value_out <= next_value;
    end
  end
endmodule

// ### src/usil_regs.sv
// Function
// - Each field is 16 bits; bits 7-0 low byte, bits 15-8 high byte.
// - Software can read the index value of the current setup request.
// - Software can read the length value of the current setup request.
// - Peripheral mode: index field stores the received setup index value.
// - Peripheral mode: software writes to the index field are ignored.
// - Peripheral mode: length field stores the received setup length value.
// - Peripheral mode: software writes to the length field are ignored.
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module usil_regs #(
  parameter int FIELD_W = usil_pkg::FIELD_W
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic rx_setup_valid_in,
  input wire logic [15:0] rx_index_in,
  input wire logic [15:0] rx_length_in,
  input wire logic tx_setup_done_in,
  output logic host_mode_out,
  output logic setup_send_request_flag_out,
  output logic [15:0] tx_index_out,
  output logic [15:0] tx_length_out
);
  generate
    if (FIELD_W != 16) begin : g_bad_width
      $error("usil_regs: FIELD_W must be 16");
    end
  endgenerate

  function automatic usil_pkg::usil_reg_t usil_decode(input logic [7:0] addr);
    case (addr)
      usil_pkg::OFF_INDEX: usil_decode = usil_pkg::USIL_REG_INDEX;
      usil_pkg::OFF_LENGTH: usil_decode = usil_pkg::USIL_REG_LENGTH;
      usil_pkg::OFF_CTRL: usil_decode = usil_pkg::USIL_REG_CTRL;
      default: usil_decode = usil_pkg::USIL_REG_NONE;
    endcase
  endfunction

  // Write channel state
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_full;
  logic next_w_full;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic do_write;
  usil_pkg::usil_reg_t wr_reg;

  always_comb begin
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid_out;
    next_bresp = s_axi_bresp_out;
    wr_reg = usil_decode(aw_addr);
    // Both halves are held until the previous response has been taken
    do_write = aw_full && w_full && !s_axi_bvalid_out;
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata_in;
      next_w_strb = s_axi_wstrb_in;
    end
    if (s_axi_bvalid_out && s_axi_bready_in) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (wr_reg == usil_pkg::USIL_REG_NONE) ? usil_pkg::RESP_SLVERR
                                                        : usil_pkg::RESP_OKAY;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= usil_pkg::RESP_OKAY;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid_out <= next_bvalid;
      s_axi_bresp_out <= next_bresp;
      s_axi_awready_out <= !next_aw_full;
      s_axi_wready_out <= !next_w_full;
    end
  end

  // Control register: mode bit and send request flag
  logic next_host_mode;
  logic next_req;
  logic set_req;
  logic ctrl_we;

  always_comb begin
    ctrl_we = do_write && (wr_reg == usil_pkg::USIL_REG_CTRL) && w_strb[0];
    next_host_mode = host_mode_out;
    if (ctrl_we) begin
      next_host_mode = w_data[usil_pkg::CTRL_HOST_BIT];
    end
    // Only a one starts a send; a zero request bit cannot cancel one in flight, but clearing host mode does
    // The same write must keep host mode, or the request would linger in peripheral mode
    set_req = ctrl_we && host_mode_out && w_data[usil_pkg::CTRL_HOST_BIT]
              && w_data[usil_pkg::CTRL_REQ_BIT];
    next_req = setup_send_request_flag_out;
    if (tx_setup_done_in || !next_host_mode) begin
      next_req = 1'b0;
    end
    if (set_req) begin
      next_req = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      host_mode_out <= usil_pkg::HOST_MODE_RST;
      setup_send_request_flag_out <= 1'b0;
    end else begin
      host_mode_out <= next_host_mode;
      setup_send_request_flag_out <= next_req;
    end
  end

  // The two setup fields; the core sends tx_index_out and tx_length_out as held
  logic idx_we;
  logic len_we;
  assign idx_we = do_write && (wr_reg == usil_pkg::USIL_REG_INDEX);
  assign len_we = do_write && (wr_reg == usil_pkg::USIL_REG_LENGTH);

  usil_field #(.WIDTH(FIELD_W)) u_index (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .host_mode_in(host_mode_out),
    .sw_we_in(idx_we),
    .sw_strb_in(w_strb[1:0]),
    .sw_data_in(w_data[15:0]),
    .cap_in(rx_setup_valid_in),
    .cap_data_in(rx_index_in),
    .value_out(tx_index_out)
  );

  usil_field #(.WIDTH(FIELD_W)) u_length (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .host_mode_in(host_mode_out),
    .sw_we_in(len_we),
    .sw_strb_in(w_strb[1:0]),
    .sw_data_in(w_data[15:0]),
    .cap_in(rx_setup_valid_in),
    .cap_data_in(rx_length_in),
    .value_out(tx_length_out)
  );

  // Read channel
  logic next_rvalid;
  logic next_arready;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  usil_pkg::usil_reg_t rd_reg;

  always_comb begin
    next_rvalid = s_axi_rvalid_out;
    next_rdata = s_axi_rdata_out;
    next_rresp = s_axi_rresp_out;
    rd_reg = usil_decode(s_axi_araddr_in);
    if (s_axi_rvalid_out && s_axi_rready_in) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      next_rvalid = 1'b1;
      next_rresp = usil_pkg::RESP_OKAY;
      case (rd_reg)
        usil_pkg::USIL_REG_INDEX: next_rdata = {16'h0000, tx_index_out};
        usil_pkg::USIL_REG_LENGTH: next_rdata = {16'h0000, tx_length_out};
        usil_pkg::USIL_REG_CTRL: next_rdata = {30'h0, setup_send_request_flag_out,
                                               host_mode_out};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = usil_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= usil_pkg::RESP_OKAY;
      s_axi_arready_out <= 1'b0;
    end else begin
      s_axi_rvalid_out <= next_rvalid;
      s_axi_rdata_out <= next_rdata;
      s_axi_rresp_out <= next_rresp;
      s_axi_arready_out <= next_arready;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (srst_in);

  chk_index_capture: assert property (
    !host_mode_out && rx_setup_valid_in |=> tx_index_out == $past(rx_index_in))
    else $error("index not captured from received setup");
  chk_length_capture: assert property (
    !host_mode_out && rx_setup_valid_in |=> tx_length_out == $past(rx_length_in))
    else $error("length not captured from received setup");
  chk_index_locked: assert property (
    !host_mode_out && !rx_setup_valid_in |=> $stable(tx_index_out))
    else $error("index changed without a received setup");
  chk_length_locked: assert property (
    !host_mode_out && !rx_setup_valid_in |=> $stable(tx_length_out))
    else $error("length changed without a received setup");
  chk_flag_clear: assert property (
    setup_send_request_flag_out && tx_setup_done_in && !set_req
    |=> !setup_send_request_flag_out)
    else $error("send request flag not cleared after setup sent");
  chk_reset_zero: assert property (@(posedge sys_clk_in) disable iff (1'b0)
    srst_in |=> tx_index_out == 16'h0000 && tx_length_out == 16'h0000)
    else $error("fields not zero after reset");
  chk_index_read: assert property (
    s_axi_arvalid_in && s_axi_arready_out && rd_reg == usil_pkg::USIL_REG_INDEX
    |=> s_axi_rvalid_out && s_axi_rdata_out == {16'h0000, $past(tx_index_out)})
    else $error("index read data wrong");
  chk_length_read: assert property (
    s_axi_arvalid_in && s_axi_arready_out && rd_reg == usil_pkg::USIL_REG_LENGTH
    |=> s_axi_rvalid_out && s_axi_rdata_out == {16'h0000, $past(tx_length_out)})
    else $error("length read data wrong");
  chk_byte_lanes: assert property (
    host_mode_out && idx_we && w_strb[1:0] == 2'h1
    |=> tx_index_out == {$past(tx_index_out[15:8]), $past(w_data[7:0])})
    else $error("low byte lane write wrong");
  // In host mode a received setup must not disturb what software loaded
  chk_index_host: assert property (
    host_mode_out && !idx_we |=> $stable(tx_index_out))
    else $error("index changed in host mode without a write");
  chk_length_host: assert property (
    host_mode_out && !len_we |=> $stable(tx_length_out))
    else $error("length changed in host mode without a write");
  chk_flag_needs_host: assert property (
    !host_mode_out |-> !setup_send_request_flag_out)
    else $error("send request flag set outside host mode");

  cov_host_send: cover property (set_req ##[1:50] tx_setup_done_in);
  cov_periph_capture: cover property (!host_mode_out && rx_setup_valid_in);
  cov_periph_write_ignored: cover property (!host_mode_out && idx_we);
  cov_low_lane_write: cover property (host_mode_out && idx_we && w_strb[1:0] == 2'h1);
  cov_host_capture_ignored: cover property (host_mode_out && rx_setup_valid_in);
endmodule

// ### test/usil_core_model.sv
`timescale 1ns/10ps
module usil_core_model (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic flag_in,
  input wire logic [15:0] tx_index_in,
  input wire logic [15:0] tx_length_in,
  input wire logic [3:0] delay_in,
  input wire logic rx_go_in,
  input wire logic [31:0] rx_word_in,
  output logic rx_valid_out,
  output logic [15:0] rx_index_out,
  output logic [15:0] rx_length_out,
  output logic done_out,
  output logic [31:0] sent_out
);
  logic [3:0] cnt;
  initial begin
    done_out = 1'b0;
    rx_valid_out = 1'b0;
    rx_index_out = 16'h0000;
    rx_length_out = 16'h0000;
  end
  always @(posedge sys_clk_in) begin
    done_out <= 1'b0;
    rx_valid_out <= rx_go_in;
    if (rx_go_in) begin
      {rx_length_out, rx_index_out} <= rx_word_in;
    end else begin
      // Fields outside the pulse toggle, so a stale value is never taken for a fresh one
      {rx_length_out, rx_index_out} <= ~{rx_length_out, rx_index_out};
    end
    if (srst_in || !flag_in || done_out) begin
      cnt <= 4'h0;
    end else if (cnt == delay_in) begin
      done_out <= 1'b1;
      sent_out <= {tx_length_in, tx_index_in};
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// ### test/usb_setup_index_length_regs_tb.sv
`timescale 1ns/10ps
module usb_setup_index_length_regs_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rx_word = 32'h0, rdata, sent, got, d;
  logic [3:0] wstrb = 4'h0, delay = 4'h0, s;
  logic awready, wready, bvalid, arready, rvalid, rxv, done, host, flag, rx_go = 1'b0;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] rxi, rxl, txi, txl, exp_i, exp_l;
  int n_errors = 0, n_compared = 0, cycles = 0, seed = 32'h64db;
  always #12.5 clk = ~clk;
  usil_regs dut (.sys_clk_in(clk), .srst_in(rst), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .rx_setup_valid_in(rxv), .rx_index_in(rxi),
    .rx_length_in(rxl), .tx_setup_done_in(done), .host_mode_out(host),
    .setup_send_request_flag_out(flag), .tx_index_out(txi), .tx_length_out(txl));
  usil_core_model core (.sys_clk_in(clk), .srst_in(rst), .flag_in(flag),
    .tx_index_in(txi), .tx_length_in(txl), .delay_in(delay), .rx_go_in(rx_go),
    .rx_word_in(rx_word), .rx_valid_out(rxv), .rx_index_out(rxi),
    .rx_length_out(rxl), .done_out(done), .sent_out(sent));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
      n_errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] st);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    got = rdata;
    resp = rresp;
  endtask
  function automatic logic [15:0] merge(input logic [15:0] o, input logic [31:0] v,
                                        input logic [3:0] st);
    return {st[1] ? v[15:8] : o[15:8], st[0] ? v[7:0] : o[7:0]};
  endfunction
  task automatic rx_setup();
    d = $random(seed);
    rx_word <= d;
    rx_go <= 1'b1;
    @(posedge clk);
    rx_go <= 1'b0;
  endtask
  task automatic check_fields();
    rd(usil_pkg::OFF_INDEX);
    chk(got, {16'h0000, exp_i});
    rd(usil_pkg::OFF_LENGTH);
    chk(got, {16'h0000, exp_l});
    chk({30'h0, resp}, {30'h0, usil_pkg::RESP_OKAY});
  endtask
  task automatic tally_and_finish();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Ceiling sits far above six rounds of register traffic
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    exp_i = 16'h0000;
    exp_l = 16'h0000;
    check_fields();
    rd(8'h0c);
    chk({got[31:2], resp}, {30'h0, usil_pkg::RESP_SLVERR});
    wr(8'h10, 32'hffff_ffff, 4'hf);
    chk({30'h0, resp}, {30'h0, usil_pkg::RESP_SLVERR});
    for (int i = 0; i < 6; i++) begin
      wr(usil_pkg::OFF_CTRL, 32'h0, 4'h1);
      wr(usil_pkg::OFF_INDEX, $random(seed), 4'h3);
      wr(usil_pkg::OFF_LENGTH, $random(seed), 4'h3);
      check_fields();
      rx_setup();
      exp_i = d[15:0];
      exp_l = d[31:16];
      check_fields();
      wr(usil_pkg::OFF_CTRL, 32'h1, 4'h1);
      chk({31'h0, host}, 32'h1);
      d = $random(seed);
      s = $random(seed);
      // First round forces a low-lane-only write as a corner case
      if (i == 0) s = 4'h1;
      wr(usil_pkg::OFF_INDEX, d, s);
      exp_i = merge(exp_i, d, s);
      d = $random(seed);
      s = $random(seed);
      wr(usil_pkg::OFF_LENGTH, d, s);
      exp_l = merge(exp_l, d, s);
      check_fields();
      // A received setup in host mode must leave the loaded fields alone
      rx_setup();
      check_fields();
      delay <= 4'(i * 3);
      wr(usil_pkg::OFF_CTRL, 32'h3, 4'h1);
      chk({31'h0, flag}, 32'h1);
      // Fields stay untouched until the flag drops
      while (flag !== 1'b0) @(posedge clk);
      chk(sent, {exp_l, exp_i});
    end
    // Mid-run reset must bring loaded fields and the mode bit back to zero
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    exp_i = 16'h0000;
    exp_l = 16'h0000;
    check_fields();
    rd(usil_pkg::OFF_CTRL);
    chk(got, 32'h0);
    tally_and_finish();
  end
endmodule
